// ---- design/psc_defs.vh ----
/*
 * Constants for the status and control register group of a 10/100 PHY:
 * management register offsets, field positions, reset values, codes of the
 * management frame and of the status fields.
 * Assumes a clause 22 style management frame on MDC/MDIO and a 200 MHz core clock.
 */
// How it works
// - test enable self-clears; results then valid
// - two-bit test outcome, reset 00
// - short-cable flag below ten meters, reset 0
// - read-only flow-control capability bit, reset 0
// - read-only link status bit
// - read-only receive polarity reversed bit
// - read-only energy detect bit
// - isolate bit shared with basic control
// - three-bit resolved speed and duplex field
// - crossover mode bit picks enhanced algorithm
// - manual crossed or straight pairs when auto off
// - pair-swap disable resets from strap pin
// - force link never raises link up
// - power-saving enable bit, reset 0
// - interrupt level bit sets pin polarity
// - jabber counter enable bit, reset 1
// - two-bit indicator mapping field, reset 00
// - transmitter disable bit
// - remote loopback bit
// - scrambler bypass bit
// - read-only resolved crossed pairs bit
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

// register offsets
`define PSC_REG_BASIC_CONTROL     5'h00
`define PSC_REG_CABLE_TEST_RESULT 5'h1d
`define PSC_REG_PHY_STATUS_ONE    5'h1e
`define PSC_REG_PHY_CONTROL_TWO   5'h1f

// basic control
`define PSC_BC_ISOLATE     10

// cable_test_result fields
`define PSC_CT_ENABLE      15
`define PSC_CT_RESULT_HI   14
`define PSC_CT_RESULT_LO   13
`define PSC_CT_SHORT       12
`define PSC_CT_COUNT_HI    8

// cable test outcome codes
`define PSC_CT_NORMAL      2'h0
`define PSC_CT_OPEN        2'h1
`define PSC_CT_SHORTED     2'h2
`define PSC_CT_FAILED      2'h3

// phy_status_one fields
`define PSC_S1_FLOW        9
`define PSC_S1_LINK        8
`define PSC_S1_POLARITY    7
`define PSC_S1_CROSSED     5
`define PSC_S1_ENERGY      4
`define PSC_S1_ISOLATE     3
`define PSC_S1_MODE_HI     2

// operating mode codes
`define PSC_MODE_NEGOTIATE 3'h0
`define PSC_MODE_10_HALF   3'h1
`define PSC_MODE_100_HALF  3'h2
`define PSC_MODE_10_FULL   3'h5
`define PSC_MODE_100_FULL  3'h6

// phy_control_two fields
`define PSC_C2_ENH_XOVER   15
`define PSC_C2_XOVER_SEL   14
`define PSC_C2_SWAP_DIS    13
`define PSC_C2_FORCE_LINK  11
`define PSC_C2_POWER_SAVE  10
`define PSC_C2_INT_LEVEL   9
`define PSC_C2_JABBER_EN   8
`define PSC_C2_LED_HI      5
`define PSC_C2_LED_LO      4
`define PSC_C2_TX_DIS      3
`define PSC_C2_REMOTE_LB   2
`define PSC_C2_SQE_EN      1
`define PSC_C2_SCR_DIS     0

// indicator mapping codes
`define PSC_LED_SPEED_LINKACT 2'h0
`define PSC_LED_ACT_LINK      2'h1

// reset values
`define PSC_RST_ENH_XOVER  1'b1
`define PSC_RST_JABBER_EN  1'b1
`define PSC_RST_ZERO1      1'b0
`define PSC_RST_LED        2'h0

// management frame
`define PSC_PREAMBLE_BITS  6'd32
`define PSC_HDR_LAST       4'd12
`define PSC_OP_WRITE       2'h1
`define PSC_OP_READ        2'h2
`define PSC_RD_LAST        5'd17
`define PSC_WR_LAST        5'd17
`define PSC_WR_TA_LAST     5'd1

`endif

// ---- design/psc_phy_status_control_regs.v ----
/*
 * Status and control register group of a 10/100 PHY, reached over the
 * MDC/MDIO management port, plus the small amount of glue that applies the
 * control bits (crossover select, interrupt polarity, indicator mapping).
 * Assumes: MDC and MDIO and the strap pin are asynchronous pins; all status
 * inputs and the cable test result come from PHY logic on core_clk.
 */
`timescale 1ns/1ps
`include "psc_defs.vh"

module psc_phy_status_control_regs #(
   parameter [4:0] PHY_ADDR = 5'h00
) (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_b,
   // management pins
   input  wire        mdc,
   input  wire        mdioIn,
   output reg         mdioOut,
   output reg         mdioOe,
   // strap pin for pair-swap disable
   input  wire        pairSwapStrap,
   // cable diagnostic engine
   input  wire        cableTestDone,
   input  wire [1:0]  cableResult,
   input  wire        cableShort,
   input  wire [8:0]  cableFaultCount,
   output reg         cableTestRun,
   // live status from the PHY
   input  wire        flowCapable,
   input  wire        linkUp,
   input  wire        polarityReversed,
   input  wire        autoCrossed,
   input  wire        energyDetect,
   input  wire [2:0]  opMode,
   input  wire        speed100,
   input  wire        activity,
   input  wire        intRequest,
   // controls to the PHY
   output reg         isolate,
   output reg         enhancedCrossoverMode,
   output reg         crossedPairSelect,
   output reg         pairSwapDisable,
   output reg         crossedPairMode,
   output reg         forceLink,
   output reg         powerSaving,
   output reg         jabberEnable,
   output reg         txDisable,
   output reg         remoteLoopback,
   output reg         sqeTestEnable,
   output reg         scramblerBypass,
   // pins driven by this block
   output reg         intPin,
   output reg         indicator_out_a,
   output reg         indicator_out_b
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_HDR   = 2'h1;
   localparam [1:0] ST_READ  = 2'h2;
   localparam [1:0] ST_WRITE = 2'h3;

   // synchronisers
   reg        mdcMeta;
   reg        mdcSync;
   reg        mdcLast;
   reg        mdioMeta;
   reg        mdioSync;
   reg        strapMeta;
   reg        strapSync;
   reg        strapLoaded;
   wire       mdcRise;

   // frame engine
   reg [1:0]  state;
   reg [5:0]  preCnt;
   reg [3:0]  hdrCnt;
   reg [4:0]  bitCnt;
   reg [12:0] hdrShift;
   reg [15:0] rdShift;
   reg [15:0] wrShift;
   reg [4:0]  regAddr;
   reg        wrEn;
   reg [15:0] wrData;
   reg [4:0]  wrAddr;
   wire [12:0] hdrFull;

   // stored fields
   reg [1:0]  testResult;
   reg        testShort;
   reg [8:0]  faultCount;
   reg [1:0]  ledMode;
   reg        intLevel;
   reg [15:0] readMux;

   assign mdcRise = mdcSync & ~mdcLast;
   assign hdrFull = {hdrShift[11:0], mdioSync};

   // two flops on each of mdc, mdioIn and pairSwapStrap; the first is read by the second only
   always @(posedge core_clk) begin
      mdcMeta   <= mdc;
      mdcSync   <= mdcMeta;
      mdioMeta  <= mdioIn;
      mdioSync  <= mdioMeta;
      strapMeta <= pairSwapStrap;
      strapSync <= strapMeta;
   end

   // edge history starts high so a released reset never fakes a rising edge
   always @(posedge core_clk) begin
      if (!rst_b) begin
         mdcLast <= 1'b1;
      end else begin
         mdcLast <= mdcSync;
      end
   end

   // read view of the registers; unmapped offsets and reserved bits read zero
   always @* begin
      readMux = 16'h0000;
      case (regAddr)
         `PSC_REG_BASIC_CONTROL: begin
            readMux[`PSC_BC_ISOLATE] = isolate;
         end
         `PSC_REG_CABLE_TEST_RESULT: begin
            readMux[`PSC_CT_ENABLE] = cableTestRun;
            readMux[`PSC_CT_RESULT_HI:`PSC_CT_RESULT_LO] = testResult;
            readMux[`PSC_CT_SHORT] = testShort;
            readMux[`PSC_CT_COUNT_HI:0] = faultCount;
         end
         `PSC_REG_PHY_STATUS_ONE: begin
            readMux[`PSC_S1_FLOW] = flowCapable;
            readMux[`PSC_S1_LINK] = linkUp;
            readMux[`PSC_S1_POLARITY] = polarityReversed;
            readMux[`PSC_S1_CROSSED] = crossedPairMode;
            readMux[`PSC_S1_ENERGY] = energyDetect;
            readMux[`PSC_S1_ISOLATE] = isolate;
            readMux[`PSC_S1_MODE_HI:0] = opMode;
         end
         `PSC_REG_PHY_CONTROL_TWO: begin
            readMux[`PSC_C2_ENH_XOVER] = enhancedCrossoverMode;
            readMux[`PSC_C2_XOVER_SEL] = crossedPairSelect;
            readMux[`PSC_C2_SWAP_DIS] = pairSwapDisable;
            readMux[`PSC_C2_FORCE_LINK] = forceLink;
            readMux[`PSC_C2_POWER_SAVE] = powerSaving;
            readMux[`PSC_C2_INT_LEVEL] = intLevel;
            readMux[`PSC_C2_JABBER_EN] = jabberEnable;
            readMux[`PSC_C2_LED_HI:`PSC_C2_LED_LO] = ledMode;
            readMux[`PSC_C2_TX_DIS] = txDisable;
            readMux[`PSC_C2_REMOTE_LB] = remoteLoopback;
            readMux[`PSC_C2_SQE_EN] = sqeTestEnable;
            readMux[`PSC_C2_SCR_DIS] = scramblerBypass;
         end
         default: begin
            readMux = 16'h0000;
         end
      endcase
   end

   // management frame engine; bits are sampled and driven at the mdc rising edge,
   // which leaves the station a full low half period of setup before its next sample
   always @(posedge core_clk) begin
      if (!rst_b) begin
         state    <= ST_IDLE;
         preCnt   <= 6'd0;
         hdrCnt   <= 4'd0;
         bitCnt   <= 5'd0;
         hdrShift <= 13'h0;
         rdShift  <= 16'h0000;
         wrShift  <= 16'h0000;
         regAddr  <= 5'h00;
         wrEn     <= 1'b0;
         wrData   <= 16'h0000;
         wrAddr   <= 5'h00;
         mdioOut  <= 1'b0;
         mdioOe   <= 1'b0;
      end else begin
         wrEn <= 1'b0;
         if (mdcRise) begin
            case (state)
               ST_IDLE: begin
                  mdioOe <= 1'b0;
                  if (mdioSync) begin
                     if (preCnt != `PSC_PREAMBLE_BITS) begin
                        preCnt <= preCnt + 6'd1;
                     end
                  end else begin
                     // a zero after a full preamble is the first start bit
                     if (preCnt == `PSC_PREAMBLE_BITS) begin
                        state  <= ST_HDR;
                        hdrCnt <= 4'd0;
                     end
                     preCnt <= 6'd0;
                  end
               end
               ST_HDR: begin
                  hdrShift <= hdrFull;
                  hdrCnt   <= hdrCnt + 4'd1;
                  if (hdrCnt == `PSC_HDR_LAST) begin
                     // hdrFull = start bit, op[1:0], phy address, register address
                     regAddr <= hdrFull[4:0];
                     bitCnt  <= 5'd0;
                     if (!hdrFull[12] || hdrFull[9:5] != PHY_ADDR) begin
                        state <= ST_IDLE;
                     end else if (hdrFull[11:10] == `PSC_OP_READ) begin
                        state <= ST_READ;
                     end else if (hdrFull[11:10] == `PSC_OP_WRITE) begin
                        state <= ST_WRITE;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_READ: begin
                  bitCnt <= bitCnt + 5'd1;
                  if (bitCnt == 5'd0) begin
                     // second turnaround bit driven low, data captured now
                     mdioOe  <= 1'b1;
                     mdioOut <= 1'b0;
                     rdShift <= readMux;
                  end else if (bitCnt == `PSC_RD_LAST) begin
                     mdioOe  <= 1'b0;
                     mdioOut <= 1'b0;
                     state   <= ST_IDLE;
                  end else begin
                     mdioOut <= rdShift[15];
                     rdShift <= {rdShift[14:0], 1'b0};
                  end
               end
               ST_WRITE: begin
                  bitCnt <= bitCnt + 5'd1;
                  if (bitCnt > `PSC_WR_TA_LAST) begin
                     wrShift <= {wrShift[14:0], mdioSync};
                  end
                  if (bitCnt == `PSC_WR_LAST) begin
                     wrEn   <= 1'b1;
                     wrData <= {wrShift[14:0], mdioSync};
                     wrAddr <= regAddr;
                     state  <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // register storage and cable test bookkeeping
   always @(posedge core_clk) begin
      if (!rst_b) begin
         cableTestRun          <= `PSC_RST_ZERO1;
         testResult            <= `PSC_CT_NORMAL;
         testShort             <= `PSC_RST_ZERO1;
         faultCount            <= 9'h0;
         isolate               <= `PSC_RST_ZERO1;
         enhancedCrossoverMode <= `PSC_RST_ENH_XOVER;
         crossedPairSelect     <= `PSC_RST_ZERO1;
         pairSwapDisable       <= `PSC_RST_ZERO1;
         strapLoaded           <= 1'b0;
         forceLink             <= `PSC_RST_ZERO1;
         powerSaving           <= `PSC_RST_ZERO1;
         intLevel              <= `PSC_RST_ZERO1;
         jabberEnable          <= `PSC_RST_JABBER_EN;
         ledMode               <= `PSC_RST_LED;
         txDisable             <= `PSC_RST_ZERO1;
         remoteLoopback        <= `PSC_RST_ZERO1;
         sqeTestEnable         <= `PSC_RST_ZERO1;
         scramblerBypass       <= `PSC_RST_ZERO1;
      end else begin
         // strap is taken on the first edge after release, once the chain has filled
         if (!strapLoaded) begin
            pairSwapDisable <= strapSync;
            strapLoaded     <= 1'b1;
         end
         // results latch on completion and the enable drops by itself
         if (cableTestDone && cableTestRun) begin
            testResult   <= cableResult;
            testShort    <= cableShort;
            faultCount   <= cableFaultCount;
            cableTestRun <= 1'b0;
         end
         if (wrEn) begin
            case (wrAddr)
               `PSC_REG_BASIC_CONTROL: begin
                  isolate <= wrData[`PSC_BC_ISOLATE];
               end
               `PSC_REG_CABLE_TEST_RESULT: begin
                  // a new start written with the finishing pulse wins over the self-clear
                  cableTestRun <= wrData[`PSC_CT_ENABLE];
               end
               `PSC_REG_PHY_STATUS_ONE: begin
                  isolate <= wrData[`PSC_S1_ISOLATE];
               end
               `PSC_REG_PHY_CONTROL_TWO: begin
                  enhancedCrossoverMode <= wrData[`PSC_C2_ENH_XOVER];
                  crossedPairSelect     <= wrData[`PSC_C2_XOVER_SEL];
                  pairSwapDisable       <= wrData[`PSC_C2_SWAP_DIS];
                  forceLink             <= wrData[`PSC_C2_FORCE_LINK];
                  powerSaving           <= wrData[`PSC_C2_POWER_SAVE];
                  intLevel              <= wrData[`PSC_C2_INT_LEVEL];
                  jabberEnable          <= wrData[`PSC_C2_JABBER_EN];
                  ledMode               <= wrData[`PSC_C2_LED_HI:`PSC_C2_LED_LO];
                  txDisable             <= wrData[`PSC_C2_TX_DIS];
                  remoteLoopback        <= wrData[`PSC_C2_REMOTE_LB];
                  sqeTestEnable         <= wrData[`PSC_C2_SQE_EN];
                  scramblerBypass       <= wrData[`PSC_C2_SCR_DIS];
               end
               default: begin
                  isolate <= isolate;
               end
            endcase
         end
      end
   end

   // applied controls; force link only touches the transmit path, linkUp passes untouched
   always @(posedge core_clk) begin
      if (!rst_b) begin
         crossedPairMode <= 1'b0;
         intPin          <= 1'b1;
         indicator_out_a <= 1'b0;
         indicator_out_b <= 1'b0;
      end else begin
         // with auto crossover off the manual select decides the pairs
         if (pairSwapDisable) begin
            crossedPairMode <= crossedPairSelect;
         end else begin
            crossedPairMode <= autoCrossed;
         end
         intPin <= intLevel ? intRequest : ~intRequest;
         // reserved mapping codes fall back to the reset mapping
         if (ledMode == `PSC_LED_ACT_LINK) begin
            indicator_out_b <= activity;
            indicator_out_a <= linkUp;
         end else begin
            indicator_out_b <= speed100;
            indicator_out_a <= linkUp & ~activity;
         end
      end
   end

endmodule

// ---- design/psc_sizecheck_none.v ----
/*
 * Holds no logic: the whole block lives in psc_phy_status_control_regs.v.
 * Assumes nothing of its surroundings.
 */

// ---- verif/psc_regs_checker.sv ----
/*
 * Port-level assertions for the phy status and control register group.
 * Assumes it is bound to psc_phy_status_control_regs and sees its ports only.
 */
`timescale 1ns/1ps
module psc_regs_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // inputs of the block
   input wire logic mdc,
   input wire logic intRequest,
   input wire logic cableTestDone,
   input wire logic autoCrossed,
   input wire logic linkUp,
   input wire logic activity,
   input wire logic speed100,
   // outputs of the block
   input wire logic intPin,
   input wire logic cableTestRun,
   input wire logic pairSwapDisable,
   input wire logic crossedPairSelect,
   input wire logic crossedPairMode,
   input wire logic indicator_out_a,
   input wire logic indicator_out_b,
   input wire logic enhancedCrossoverMode,
   input wire logic jabberEnable,
   input wire logic powerSaving,
   input wire logic isolate,
   input wire logic sqeTestEnable
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // reset-value checks must run while reset is low, so they switch the disable off
   runClear_a: assert property (cableTestRun && cableTestDone |=> !cableTestRun)
      else $error("test enable did not self-clear");
   ctlReset_a: assert property (disable iff (1'b0) !rst_b |=> enhancedCrossoverMode && jabberEnable
         && !powerSaving && !isolate && !sqeTestEnable && !cableTestRun)
      else $error("control reset value wrong");
   intReset_a: assert property (disable iff (1'b0) !rst_b |=> intPin)
      else $error("interrupt pin not idle high in reset");
   // with mdc idle no write can retune the polarity, so the pin must follow
   intFollow_a: assert property ((!mdc)[*8] ##0 $changed(intRequest) |=> $changed(intPin))
      else $error("interrupt pin did not follow request");
   xoverFollow_a: assert property (pairSwapDisable == $past(pairSwapDisable) |->
         crossedPairMode == ($past(pairSwapDisable) ? $past(crossedPairSelect) : $past(autoCrossed)))
      else $error("crossed pair mode wrong");
   indA_a: assert property (!$past(linkUp) |-> !indicator_out_a)
      else $error("indicator a lit without link");
   indB_a: assert property (!$past(speed100) && !$past(activity) |-> !indicator_out_b)
      else $error("indicator b lit without cause");
   ctlHold_a: assert property ((!mdc)[*8] |-> $stable({enhancedCrossoverMode, jabberEnable,
         powerSaving, isolate, sqeTestEnable, crossedPairSelect}))
      else $error("control changed without a frame");
endmodule

bind psc_phy_status_control_regs psc_regs_checker i_chk (
   .core_clk, .rst_b, .mdc, .intRequest, .cableTestDone, .autoCrossed, .linkUp, .activity, .speed100,
   .intPin, .cableTestRun, .pairSwapDisable, .crossedPairSelect, .crossedPairMode, .indicator_out_a,
   .indicator_out_b, .enhancedCrossoverMode, .jabberEnable, .powerSaving, .isolate, .sqeTestEnable);

// ---- verif/psc_mdio_station.sv ----
/*
 * Management station model: clause 22 style frames on MDC/MDIO.
 * Assumes the bench resolves the shared MDIO wire (pull-up) and feeds it back on line.
 */
`timescale 1ns/1ps
module psc_mdio_station (
   // clock
   input  wire logic core_clk,
   // wire level seen on MDIO
   input  wire logic line,
   // driven by the station
   output logic      mdc,
   output logic      drv,
   output logic      oe
);
   localparam int HALF = 4;

   // mdc stands low between frames
   initial begin
      mdc = 1'b0;
      drv = 1'b1;
      oe  = 1'b0;
   end

   // one mdc period; the wire is sampled just before the rise, five and a half core cycles after the block set it
   task automatic tick(input logic b, input logic en, output logic smp);
      drv = b;
      oe  = en;
      repeat (HALF) @(negedge core_clk);
      smp = line;
      mdc = 1'b1;
      repeat (HALF) @(negedge core_clk);
      mdc = 1'b0;
   endtask

   task automatic frame(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd, output logic taOk);
      logic [13:0] hdr;
      logic [17:0] wbits;
      logic        s;
      hdr   = {2'b01, op, phy, ra};
      wbits = {2'b10, wd};
      rd    = 16'h0000;
      taOk  = 1'b1;
      for (int i = 0; i < 32; i++) tick(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) tick(hdr[i], 1'b1, s);
      if (op == 2'b01) begin
         for (int i = 17; i >= 0; i--) tick(wbits[i], 1'b1, s);
      end else begin
         // released turnaround: the block must pull the second half low
         tick(1'b1, 1'b0, s);
         tick(1'b1, 1'b0, s);
         taOk = (s === 1'b0);
         for (int i = 15; i >= 0; i--) begin
            tick(1'b1, 1'b0, s);
            rd[i] = s;
         end
      end
      oe = 1'b0;
      // one idle cycle so a following frame never re-drives oe in the same step
      @(negedge core_clk);
   endtask
endmodule

// ---- verif/psc_phy_status_control_regs_tb_top.sv ----
/*
 * Self-checking bench for the phy status and control register group.
 * Assumes a station model on MDIO and a pull-up on the shared wire.
 */
`timescale 1ns/1ps
module psc_phy_status_control_regs_tb_top;
   localparam logic [4:0] PHY = 5'h03;
   logic core_clk, rst_b, mdc, staDrv, staOe, mdioOut, mdioOe, pairSwapStrap;
   logic cableTestDone, cableShort, cableTestRun, flowCapable, linkUp, polarityReversed;
   logic autoCrossed, energyDetect, speed100, activity, intRequest, isolate, intPin;
   logic enhancedCrossoverMode, crossedPairSelect, pairSwapDisable, crossedPairMode, forceLink;
   logic powerSaving, jabberEnable, txDisable, remoteLoopback, sqeTestEnable, scramblerBypass;
   logic indicator_out_a, indicator_out_b, ok;
   logic [1:0]  cableResult;
   logic [8:0]  cableFaultCount;
   logic [2:0]  opMode;
   logic [15:0] rd;
   int          fails, check_count;
   // pull-up wins only when neither side drives
   wire         mdioLine = mdioOe ? mdioOut : (staOe ? staDrv : 1'b1);

   psc_phy_status_control_regs #(.PHY_ADDR(PHY)) i_dut (.core_clk, .rst_b, .mdc, .mdioIn(mdioLine),
      .mdioOut, .mdioOe, .pairSwapStrap, .cableTestDone, .cableResult, .cableShort, .cableFaultCount,
      .cableTestRun, .flowCapable, .linkUp, .polarityReversed, .autoCrossed, .energyDetect, .opMode,
      .speed100, .activity, .intRequest, .isolate, .enhancedCrossoverMode, .crossedPairSelect,
      .pairSwapDisable, .crossedPairMode, .forceLink, .powerSaving, .jabberEnable, .txDisable,
      .remoteLoopback, .sqeTestEnable, .scramblerBypass, .intPin, .indicator_out_a, .indicator_out_b);
   psc_mdio_station i_sta (.core_clk, .line(mdioLine), .mdc, .drv(staDrv), .oe(staOe));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // a write lands a few core cycles after the last rise
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      i_sta.frame(PHY, 2'b01, ra, d, rd, ok);
      repeat (4) @(negedge core_clk);
   endtask
   task automatic rdx(input string nm, input logic [4:0] ra, input logic [15:0] exp);
      i_sta.frame(PHY, 2'b10, ra, 16'h0000, rd, ok);
      chk("turnaround", 16'h0001, {15'h0, ok});
      chk(nm, exp, rd);
   endtask

   task automatic t_reset;
      rdx("control two reset", 5'h1f, 16'ha100);
      rdx("cable reset", 5'h1d, 16'h0000);
      rdx("unmapped reg", 5'h10, 16'h0000);
   endtask

   task automatic t_status;
      logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
      logic [4:0] pat;
      wr(5'h1f, 16'h8100);
      for (int i = 0; i < 5; i++) begin
         pat = i[0] ? 5'h15 : 5'h0a;
         {flowCapable, linkUp, polarityReversed, autoCrossed, energyDetect} = pat;
         opMode = modes[i];
         repeat (3) @(negedge core_clk);
         rdx("status one", 5'h1e, {6'h0, pat[4:2], 1'b0, pat[1:0], 1'b0, modes[i]});
      end
   endtask

   task automatic t_control;
      logic [15:0] v;
      for (int k = 0; k < 2; k++) begin
         v = k ? 16'h0000 : 16'hffff;
         wr(5'h1f, v);
         rdx("control two", 5'h1f, v & 16'hef3f);
         chk("control pins", {6'h0, {10{v[0]}}}, {6'h0, enhancedCrossoverMode, crossedPairSelect, pairSwapDisable,
             forceLink, powerSaving, jabberEnable, txDisable, remoteLoopback, sqeTestEnable, scramblerBypass});
         chk("crossed pair mode", {15'h0, v[13] ? v[14] : autoCrossed}, {15'h0, crossedPairMode});
         repeat (8) @(negedge core_clk);
         intRequest = 1'b1;
         repeat (2) @(negedge core_clk);
         chk("interrupt pin", {15'h0, v[0]}, {15'h0, intPin});
         intRequest = 1'b0;
      end
      {linkUp, activity, speed100} = 3'b110;
      for (int m = 0; m < 4; m++) begin
         wr(5'h1f, {10'h0, m[1:0], 4'h0});
         chk("indicators", {14'h0, (m == 1) ? 2'b11 : 2'b00}, {14'h0, indicator_out_b, indicator_out_a});
      end
      // a frame for another port must leave the registers alone
      i_sta.frame(5'h04, 2'b01, 5'h1f, 16'hffff, rd, ok);
      rdx("foreign address", 5'h1f, 16'h0030);
   endtask

   task automatic t_isolate;
      {flowCapable, linkUp, polarityReversed, autoCrossed, energyDetect, activity, opMode} = 9'h0;
      wr(5'h00, 16'h0400);
      chk("isolate pin", 16'h0001, {15'h0, isolate});
      rdx("status isolate", 5'h1e, 16'h0008);
      wr(5'h1e, 16'hfff7);
      rdx("basic control", 5'h00, 16'h0000);
   endtask

   task automatic t_cable;
      logic [8:0] cnt;
      for (int c = 0; c < 4; c++) begin
         cnt = 9'h1a5 ^ c[8:0];
         wr(5'h1d, 16'h8000);
         chk("test running", 16'h0001, {15'h0, cableTestRun});
         {cableResult, cableShort, cableFaultCount, cableTestDone} = {c[1:0], c[0], cnt, 1'b1};
         @(negedge core_clk);
         cableTestDone = 1'b0;
         @(negedge core_clk);
         chk("test cleared", 16'h0000, {15'h0, cableTestRun});
         // results must stay latched after the engine moves on
         {cableResult, cableShort, cableFaultCount} = ~{c[1:0], c[0], cnt};
         rdx("cable result", 5'h1d, {1'b0, c[1:0], c[0], 3'h0, cnt});
      end
   endtask

   task automatic results;
      $display("checks %0d failures %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // three reset cycles; the strap chain has filled by the release
   initial begin
      rst_b = 1'b0;
      pairSwapStrap = 1'b1;
      {cableTestDone, cableResult, cableShort, cableFaultCount, opMode} = 15'h0;
      {flowCapable, linkUp, polarityReversed, autoCrossed, energyDetect} = 5'h00;
      {speed100, activity, intRequest} = 3'b000;
      fails = 0;
      check_count = 0;
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      t_reset;
      t_status;
      t_control;
      t_isolate;
      t_cable;
      results;
   end
endmodule
